// file: verilog/dpo_regs.svh
// Purpose: constants for the decimal parallel output port
// Assumes: 50 MHz clock
// Notes: offsets are byte addresses on the register bus
`ifndef DPO_REGS_SVH
`define DPO_REGS_SVH
`define DPO_OFS_VALUE 4'h0
`define DPO_OFS_CTRL 4'h4
`define DPO_OFS_STATUS 4'h8
`define DPO_CTRL_POL_BIT 0
`define DPO_CTRL_SETUP_BIT 1
`define DPO_CTRL_KEY_BIT 2
`define DPO_CTRL_STORE_BIT 3
`define DPO_POL_RESET 1'b0
`define DPO_STROBE_NS 1000
`define DPO_CLK_MHZ 50
`define DPO_STROBE_CYC ((`DPO_STROBE_NS * `DPO_CLK_MHZ + 999) / 1000)
`define DPO_SETUP_ITEM 8'h0A
`endif

// file: verilog/dpo_pkg.sv
// Purpose: types for the decimal parallel output port
// Assumes: nothing
// Notes: digit count fixed by the display
package dpo_pkg;
  typedef enum logic [1:0] {DPO_IDLE, DPO_LOAD, DPO_HOLDLOW} dpo_state_e;
  typedef logic [3:0] dpo_digit_t;
endpackage : dpo_pkg

// file: verilog/dpo_encode.sv
// Purpose: applies polarity and select to the parallel lines
// Assumes: data inputs are registered upstream
// Notes: registered so every top output is a flip-flop
`timescale 1ns/1ns
module dpo_encode #(
  parameter int W = 30
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] data,
  input wire logic pol_positive,
  input wire logic select_n,
  output logic [W-1:0] lines,
  output logic [W-1:0] lines_oe
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lines <= '0;
    end else begin
      // negative logic: a 0 bit drives high
      lines <= pol_positive ? data : ~data;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lines_oe <= '0;
    end else begin
      // select low floats every line
      lines_oe <= select_n ? '1 : '0;
    end
  end
endmodule : dpo_encode

// file: verilog/dpo_top.sv
// Purpose: six-digit bcd parallel output port with register access
// Assumes: inputs synchronous to clock; master keeps other rules
// Notes: polarity applies to digits and point; flags and strobe stay low-active
`timescale 1ns/1ns
`include "dpo_regs.svh"
module dpo_top #(
  parameter int DIGITS = 6,
  parameter int STROBE_CYC = `DPO_STROBE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic freeze_n,
  input wire logic select_n,
  output logic [29:0] port_out,
  output logic [29:0] port_oe
);
  import dpo_pkg::*;
  localparam int W = DIGITS * 4 + 6;
  dpo_state_e state_r;
  logic [31:0] value_r;
  logic pol_r;
  logic pol_edit_r;
  logic setup_r;
  logic [7:0] item_r;
  logic [23:0] bcd_r;
  logic ovr_r;
  logic pos_r;
  logic [2:0] dp_r;
  logic strobe_n_r;
  logic pending_r;
  logic [15:0] cnt_r;
  logic ack_r;
  logic [W-1:0] data_w;
  logic wr_go;
  logic rd_go;
  logic req_new;
  logic [2:0] flag_w;
  wire logic [23:0] bcd_fix;
  genvar gi;

  function automatic logic is_ofs(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction : is_ofs

  // a nibble above nine is no bcd code; nine is sent instead
  function automatic dpo_digit_t bcd_clamp(input dpo_digit_t d);
    return (d > 4'h9) ? 4'h9 : d;
  endfunction : bcd_clamp

  // more than four places is shown as four
  function automatic logic [2:0] dp_clamp(input logic [2:0] p);
    return (p > 3'h4) ? 3'h4 : p;
  endfunction : dp_clamp

  // readback words; spare bits read as zero
  function automatic logic [31:0] ctrl_word(input logic [7:0] item,
      input logic setup, input logic edit, input logic pol);
    return {item, 21'h0, setup, edit, pol};
  endfunction : ctrl_word

  function automatic logic [31:0] status_word(input logic [3:0] low,
      input logic pend, input logic frz, input logic strb, input logic busy);
    return {24'h0, low, pend, frz, strb, busy};
  endfunction : status_word

  // a new request is one not yet answered
  assign req_new = (avs_read || avs_write) && !ack_r;
  assign wr_go = avs_write && !ack_r;
  assign rd_go = avs_read && !ack_r;

  // one wait cycle per access, then answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req_new;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !req_new;
    end
  end

  // value word: bits 23:0 bcd, 24 overflow, 25 positive, 28:26 dp
  // newest write wins; one written during freeze waits as pending
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      value_r <= 32'h0;
      pending_r <= 1'b0;
    end else if (wr_go && is_ofs(avs_address, `DPO_OFS_VALUE)) begin
      value_r <= avs_writedata;
      pending_r <= 1'b1;
    end else if (state_r == DPO_LOAD) begin
      pending_r <= 1'b0;
    end
  end

  // polarity setup item; key toggles edit copy, store commits
  // a store outside setup is ignored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pol_r <= `DPO_POL_RESET;
      pol_edit_r <= `DPO_POL_RESET;
      setup_r <= 1'b0;
      item_r <= `DPO_SETUP_ITEM;
    end else if (wr_go && is_ofs(avs_address, `DPO_OFS_CTRL)) begin
      if (avs_writedata[`DPO_CTRL_STORE_BIT] && setup_r) begin
        pol_r <= pol_edit_r;
        setup_r <= 1'b0;
      end else if (avs_writedata[`DPO_CTRL_SETUP_BIT]) begin
        setup_r <= 1'b1;
        pol_edit_r <= pol_r;
        item_r <= `DPO_SETUP_ITEM;
        if (avs_writedata[`DPO_CTRL_KEY_BIT] && setup_r) begin
          pol_edit_r <= ~pol_edit_r;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (rd_go) begin
      case (avs_address)
        `DPO_OFS_VALUE: avs_readdata <= value_r;
        `DPO_OFS_CTRL: avs_readdata <= ctrl_word(item_r, setup_r,
                                                 pol_edit_r, pol_r);
        `DPO_OFS_STATUS: avs_readdata <= status_word(bcd_r[3:0], pending_r,
            !freeze_n, !strobe_n_r, state_r != DPO_IDLE);
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // transfer: strobe low first, data moves inside low phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= DPO_IDLE;
      cnt_r <= 16'h0;
      strobe_n_r <= 1'b1;
    end else begin
      case (state_r)
        DPO_IDLE: begin
          // freeze only blocks a start; a transfer under way completes
          if (pending_r && freeze_n) begin
            strobe_n_r <= 1'b0;
            state_r <= DPO_LOAD;
          end
        end
        DPO_LOAD: begin
          cnt_r <= 16'(STROBE_CYC);
          state_r <= DPO_HOLDLOW;
        end
        DPO_HOLDLOW: begin
          if (cnt_r <= 16'h1) begin
            strobe_n_r <= 1'b1;
            state_r <= DPO_IDLE;
          end else begin
            cnt_r <= cnt_r - 16'h1;
          end
        end
        default: state_r <= DPO_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bcd_r <= 24'h0;
      ovr_r <= 1'b0;
      pos_r <= 1'b0;
      dp_r <= 3'h0;
    end else if (state_r == DPO_LOAD) begin
      bcd_r <= bcd_fix;
      ovr_r <= value_r[24];
      pos_r <= value_r[25];
      dp_r <= dp_clamp(value_r[28:26]);
    end
  end

  // flags and strobe stay low-active in both polarities; the encoder
  // inverts in negative logic, so they are flipped first in positive
  assign flag_w = {ovr_r, pos_r, !strobe_n_r} ^ {3{pol_r}};
  assign data_w = {dp_r, flag_w, bcd_r};

  generate
    for (gi = 0; gi < DIGITS; gi++) begin : g_digit
      assign bcd_fix[gi*4 +: 4] = bcd_clamp(value_r[gi*4 +: 4]);
    end
  endgenerate

  dpo_encode #(.W(W)) u_enc (
    .clock(clock),
    .rst(rst),
    .data(data_w),
    .pol_positive(pol_r),
    .select_n(select_n),
    .lines(port_out),
    .lines_oe(port_oe)
  );
endmodule : dpo_top

// file: bench/dpo_chk.sv
// Purpose: port timing checks
// Assumes: a polarity store inverts digits and point only
// Notes: an inversion is not a transfer
`timescale 1ns/1ns
module dpo_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic freeze_n,
  input wire logic select_n,
  input wire logic [29:0] port_out,
  input wire logic [29:0] port_oe
);
  logic [29:0] q_r;
  wire v = port_out[23:0] != ~q_r[23:0];
  wire s = port_out[24];
  always_ff @(posedge clock or posedge rst)
    if (rst) q_r <= '0;
    else q_r <= port_out;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_oe_off: assert property (!select_n |=> !port_oe)
    else $error("oe on");
  chk_oe_on: assert property ($rose(select_n) |=> &port_oe)
    else $error("oe off");
  chk_rst_neg: assert property ($fell(rst) |=> &port_out)
    else $error("reset");
  chk_dig_strb: assert property ($changed(port_out[23:0]) && v
    |-> $stable(s) && $past(s) != $past(s, 2)) else $error("digits");
  chk_flag: assert property (v && $changed(port_out[26:25])
    |-> $past(s) != $past(s, 2)) else $error("flags");
  chk_point: assert property (v && !$stable(port_out[29:27])
    |-> $stable(s)) else $error("point");
  chk_frz_hold: assert property (!freeze_n [*5]
    |=> $stable(port_out[23:0])) else $error("frozen");
  chk_strb_len: assert property ($changed(s) && v |=> $stable(s))
    else $error("strobe");
  cov_xfer: cover property (v && $changed(port_out[23:0]));
  cov_hiz: cover property (!select_n [*2]);
  cov_frz: cover property (!freeze_n [*5]);
endmodule : dpo_chk
bind dpo_top dpo_chk u_chk (.*);

// file: bench/dpo_plc.sv
// Purpose: receiver model, latches each transfer
// Assumes: pull-ups on all lines
// Notes: pol sets digit and point levels; flags and strobe stay low-active
`timescale 1ns/1ns
module dpo_plc (
  input wire logic clock,
  input wire logic pol,
  input wire logic [29:0] port_out,
  input wire logic [29:0] port_oe,
  output logic [29:0] got,
  output int n_got
);
  wire [29:0] inv = pol ? 30'h07000000 : 30'h3FFFFFFF;
  // pull-ups float released lines high
  wire [29:0] v = (port_out | ~port_oe) ^ inv;
  bit s_r;
  always @(posedge clock) begin
    s_r <= v[24];
    if (s_r && !v[24]) begin
      got <= v;
      n_got <= n_got + 1;
    end
  end
endmodule : dpo_plc

// file: bench/dpo_top_tb.sv
// Purpose: bcd port bench
// Assumes: strobe count cut to 2
// Notes: values checked as the receiver latches them
`timescale 1ns/1ns
`include "dpo_regs.svh"
module dpo_top_tb;
  logic clock = 1'b0, rst = 1'b1, pol = 1'b0, avs_read = 1'b0;
  logic avs_write = 1'b0, freeze_n = 1'b1, select_n = 1'b1;
  logic avs_waitrequest;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [29:0] port_out, port_oe, got;
  int n_got, error_cnt, n_compared, k, n0;
  logic [63:0] row [5] = '{64'h06123456_0A123456, 64'h11999999_24999999,
    64'h1F000000_26000000, 64'h0E500001_1A500001,
    64'h0400000F_08000009};
  always #10 clock = ~clock;
  dpo_top #(.STROBE_CYC(2)) dut (.*);
  dpo_plc u_plc (.*);
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic stop(input logic bad);
    if (bad) begin
      error_cnt++;
      $display("CHECK FAILED %0t timeout", $time);
      results();
    end
  endtask : stop
  task automatic cmp(input logic [31:0] a, input logic [31:0] e);
    n_compared++;
    if (a !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, a, e);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    stop(i == 50);
    @(posedge clock);
  endtask : bus
  task automatic wt();
    int i;
    for (i = 0; i < 200 && n_got == n0; i++) @(posedge clock);
    stop(n_got == n0);
  endtask : wt
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(1'b0, `DPO_OFS_CTRL, 32'h0);
    cmp(rd[0], 1'b0);
    cmp(rd[31:24], `DPO_SETUP_ITEM);
    bus(1'b0, 4'hC, 32'h0);
    cmp(rd, 32'h0);
    for (k = 0; k < 5; k++) begin
      n0 = n_got;
      bus(1'b1, `DPO_OFS_VALUE, row[k][63:32]);
      wt();
      cmp(got, row[k][31:0]);
    end
    $display("rows done");
    freeze_n <= 1'b0;
    n0 = n_got;
    bus(1'b1, `DPO_OFS_VALUE, row[0][63:32]);
    repeat (20) @(posedge clock);
    cmp(n_got, n0);
    bus(1'b0, `DPO_OFS_STATUS, 32'h0);
    cmp(rd, 32'h9C);
    freeze_n <= 1'b1;
    wt();
    cmp(got, row[0][31:0]);
    select_n <= 1'b0;
    repeat (2) @(posedge clock);
    cmp(port_oe, 32'h0);
    select_n <= 1'b1;
    repeat (2) @(posedge clock);
    cmp(port_oe, 32'h3FFFFFFF);
    $display("freeze and select done");
    // no input while setting polarity
    for (k = 0; k < 4; k++) begin
      bus(1'b1, `DPO_OFS_CTRL,
        {`DPO_SETUP_ITEM, 20'h0, (k > 0) ? 4'h6 : 4'h2});
      bus(1'b0, `DPO_OFS_CTRL, 32'h0);
      cmp(rd[2:1], {1'b1, k[0]});
    end
    bus(1'b1, `DPO_OFS_CTRL, {`DPO_SETUP_ITEM, 24'h8});
    bus(1'b0, `DPO_OFS_CTRL, 32'h0);
    cmp({rd[2], rd[0]}, 2'h1);
    pol <= 1'b1;
    repeat (2) @(posedge clock);
    n0 = n_got;
    bus(1'b1, `DPO_OFS_VALUE, row[1][63:32]);
    wt();
    cmp(got, row[1][31:0]);
    cmp(port_out, {3'h4, 1'b0, 1'b1, 1'b1, 24'h999999});
    $display("polarity done");
    rst <= 1'b1;
    pol <= 1'b0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    cmp(port_out, 32'h3FFFFFFF);
    bus(1'b0, `DPO_OFS_CTRL, 32'h0);
    cmp(rd[2:0], 3'h0);
    $display("reset done");
    results();
  end
endmodule : dpo_top_tb
